// *** hdl/lmb_steer_defs.vh ***
// Constants for the data-side local memory bus master.
// Included by bare name from the design files; definitions only.
`ifndef LOCAL_MEM_STEER_DEFS_VH
`define LOCAL_MEM_STEER_DEFS_VH

// Transfer size codes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Lane enable patterns, bit 3 is the most significant lane
`define LANES_NONE 4'h0
`define LANES_B3 4'h1
`define LANES_B2 4'h2
`define LANES_B1 4'h4
`define LANES_B0 4'h8
`define LANES_H1 4'h3
`define LANES_H0 4'hC
`define LANES_WORD 4'hF

// Controller states
`define ST_IDLE 2'h0
`define ST_BUSY 2'h1

`endif

// *** hdl/lane_steer.v ***
// Byte-lane steering for loads and stores on a 32-bit local bus.
// Pure combinational; the caller registers its outputs.
`include "lmb_steer_defs.vh"

module lane_steer (
  // Access description
  input wire [1:0] size_i,
  input wire [1:0] addr_lo_i,
  // Store source and load bus data
  input wire [31:0] store_src_i,
  input wire [31:0] bus_rd_i,
  // Steered results
  output reg [3:0] lanes_o,
  output reg [31:0] bus_wr_o,
  output reg [31:0] load_val_o
);

  // Lane decode and steering for each size
  always @* begin
    lanes_o = `LANES_NONE;
    bus_wr_o = 32'h00000000;
    load_val_o = 32'h00000000;
    case (size_i)
      `SIZE_BYTE: begin
        // Low source byte mirrored to all lanes [R11]
        bus_wr_o = {4{store_src_i[7:0]}};
        case (addr_lo_i)
          2'h3: begin
            lanes_o = `LANES_B3; // [R10]
            load_val_o = {24'h000000, bus_rd_i[7:0]};
          end
          2'h2: begin
            lanes_o = `LANES_B2;
            load_val_o = {24'h000000, bus_rd_i[15:8]};
          end
          2'h1: begin
            lanes_o = `LANES_B1;
            load_val_o = {24'h000000, bus_rd_i[23:16]};
          end
          default: begin
            lanes_o = `LANES_B0; // Left-justified byte slave [R12]
            load_val_o = {24'h000000, bus_rd_i[31:24]};
          end
        endcase
      end
      `SIZE_HALF: begin
        bus_wr_o = {2{store_src_i[15:0]}}; // [R11]
        if (addr_lo_i[1]) begin
          lanes_o = `LANES_H1; // [R10]
          load_val_o = {16'h0000, bus_rd_i[15:0]};
        end else begin
          lanes_o = `LANES_H0; // [R12]
          load_val_o = {16'h0000, bus_rd_i[31:16]};
        end
      end
      default: begin
        lanes_o = `LANES_WORD; // Word lanes in order [R10]
        bus_wr_o = store_src_i; // [R11]
        load_val_o = bus_rd_i;
      end
    endcase
  end

endmodule

// *** hdl/local_mem_bus_data_steering.v ***
// Data-side master of the single-clock local memory bus.
// Assumes the core issues one request at a time and the memory answers with xfer_done_in_i.
`include "lmb_steer_defs.vh"

// Notes on behaviour
// R1: Write-active rises in first write cycle, falls the cycle after completion.
// R2: Back-to-back write keeps write-active high without a gap.
// R3: Memory presents read data on the completion edge; captured only then.
// R4: Completion ends the transfer; next may start the following cycle.
// R5: Completion sampled only at rising edges; first high edge finishes.
// R6: Memory signals write completion only after enabled lanes are stored.
// R7: All bus signals are synchronous to the one core clock.
// R8: Byte, halfword and word accesses supported with lane steering.
// R9: No bus sizing or conversion cycles; oversize accesses are not handled.
// R10: Load lane decode per low address bits, data right-aligned.
// R11: Store data low byte or halfword replicated onto chosen lanes.
// R12: Works with left-justified byte and halfword slaves.
// R13: Address strobe high only in the first cycle of each transfer.
// R14: Address and lane enables valid while the strobe is high.
// R15: Write data held from strobe cycle until completion is sampled.
// R16: Read-active rises in first read cycle, stays high back-to-back.
// R17: One transfer outstanding; read-active and write-active never both high.
module local_mem_bus_data_steering (
  // Clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // Core request side
  input wire req_valid_i,
  input wire req_write_i,
  input wire [1:0] req_size_i,
  input wire [31:0] req_addr_i,
  input wire [31:0] req_wdata_i,
  output wire req_ready_o,
  // Core load result side
  output reg load_valid_o,
  output reg [31:0] load_data_o,
  // Local memory bus
  output reg [31:0] mem_addr_o,
  output reg [3:0] byte_lanes_o,
  output reg [31:0] mem_wdata_o,
  output reg addr_qualify_pulse_o,
  output reg read_active_o,
  output reg write_active_o,
  input wire [31:0] mem_rdata_i,
  input wire xfer_done_in_i
);

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] size_reg;
  reg [1:0] addr_lo_reg;
  wire [3:0] lanes_w;
  wire [31:0] wr_steer_w;
  wire [31:0] load_steer_w;
  wire start_w;
  wire finish_w;

  // Completion seen on this edge while busy [R5]
  assign finish_w = (state_reg == `ST_BUSY) && xfer_done_in_i;
  // Accept only when idle or finishing: one outstanding [R17] [R4]
  assign req_ready_o = (state_reg == `ST_IDLE) || finish_w;
  assign start_w = req_valid_i && req_ready_o;

  // Steering for the new request; load path uses the held size
  lane_steer u_steer_wr (
    .size_i(req_size_i),
    .addr_lo_i(req_addr_i[1:0]),
    .store_src_i(req_wdata_i),
    .bus_rd_i(32'h00000000),
    .lanes_o(lanes_w),
    .bus_wr_o(wr_steer_w),
    .load_val_o()
  );

  lane_steer u_steer_rd (
    .size_i(size_reg),
    .addr_lo_i(addr_lo_reg),
    .store_src_i(32'h00000000),
    .bus_rd_i(mem_rdata_i),
    .lanes_o(),
    .bus_wr_o(),
    .load_val_o(load_steer_w)
  );

  // Next state
  always @* begin
    case (state_reg)
      `ST_IDLE: state_next = start_w ? `ST_BUSY : `ST_IDLE;
      `ST_BUSY: begin
        if (finish_w) begin
          state_next = start_w ? `ST_BUSY : `ST_IDLE; // [R4]
        end else begin
          state_next = `ST_BUSY;
        end
      end
      default: state_next = `ST_IDLE;
    endcase
  end

  // Bus drive and capture, all on the core clock [R7]
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= `ST_IDLE;
      size_reg <= `SIZE_WORD;
      addr_lo_reg <= 2'h0;
      mem_addr_o <= 32'h00000000;
      byte_lanes_o <= `LANES_NONE;
      mem_wdata_o <= 32'h00000000;
      addr_qualify_pulse_o <= 1'b0;
      read_active_o <= 1'b0;
      write_active_o <= 1'b0;
      load_valid_o <= 1'b0;
      load_data_o <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      // Strobe only in the first cycle [R13]
      addr_qualify_pulse_o <= start_w;
      load_valid_o <= 1'b0;
      if (start_w) begin
        // Address and lanes launched with the strobe [R14] [R8] [R9]
        mem_addr_o <= req_addr_i;
        byte_lanes_o <= lanes_w;
        size_reg <= req_size_i;
        addr_lo_reg <= req_addr_i[1:0];
        // Write data stands until completion [R15]
        mem_wdata_o <= req_write_i ? wr_steer_w : 32'h00000000;
        // Gapless when starting right after completion [R2] [R16] [R17]
        write_active_o <= req_write_i; // [R1]
        read_active_o <= ~req_write_i;
      end else if (finish_w) begin
        // Drop in the cycle after completion [R1] [R16]
        write_active_o <= 1'b0;
        read_active_o <= 1'b0;
      end
      // Capture read data only on the completion edge [R3] [R10]
      if (finish_w && read_active_o) begin
        load_valid_o <= 1'b1;
        load_data_o <= load_steer_w;
      end
    end
  end

endmodule

// *** test/steer_chk_sva.sv ***
// Checker on the local bus master ports.
// Bound to the top module below; one clock domain.
module steer_chk (
  input logic clock_i,
  input logic sys_rst_i,
  input logic req_valid_i,
  input logic req_write_i,
  input logic [1:0] req_size_i,
  input logic [31:0] req_addr_i,
  input logic req_ready_o,
  input logic [3:0] byte_lanes_o,
  input logic [31:0] mem_wdata_o,
  input logic addr_qualify_pulse_o,
  input logic read_active_o,
  input logic write_active_o,
  input logic xfer_done_in_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  wire take = req_valid_i && req_ready_o;
  // Completion with no request queued behind it
  sequence end_s; xfer_done_in_i && !take; endsequence
  // Strobe, lanes, activity levels and write data hold
  pulse_on_a: assert property (take |=> addr_qualify_pulse_o) else $error("no strobe");
  pulse_off_a: assert property (!take |=> !addr_qualify_pulse_o) else $error("extra strobe");
  byte_lane_a: assert property (take && req_size_i == 0 |=>
    byte_lanes_o == 4'h8 >> $past(req_addr_i[1:0])) else $error("bad lanes");
  wr_rise_a: assert property (take && req_write_i |=> write_active_o) else $error("no write");
  wr_fall_a: assert property (write_active_o ##0 end_s |=> !write_active_o) else $error("write stuck");
  rd_fall_a: assert property (read_active_o ##0 end_s |=> !read_active_o) else $error("read stuck");
  one_kind_a: assert property (!(read_active_o && write_active_o)) else $error("both active");
  wdata_hold_a: assert property (write_active_o && !xfer_done_in_i |=> $stable(mem_wdata_o))
    else $error("data moved");
endmodule
bind local_mem_bus_data_steering steer_chk chk_u (.*);

// *** test/mem_model.sv ***
// Block RAM model answering the local bus master.
// Completes lag_i cycles after the strobe; four words deep.
module mem_model (
  input logic clock_i,
  input logic strobe_i,
  input logic wr_i,
  input logic [1:0] lag_i,
  input logic [3:0] lanes_i,
  input logic [31:0] addr_i,
  input logic [31:0] wdata_i,
  output logic done_o,
  output logic [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [4];
  logic [5:0] q;
  logic [1:0] cnt;
  logic act = 0;
  wire [5:0] cur = strobe_i ? {lanes_i, addr_i[3:2]} : q;
  // Done after the wait; data garbled when not done
  assign done_o = strobe_i ? lag_i == 0 : act && cnt == 0;
  assign rdata_o = done_o ? mem[cur[1:0]] : ~mem[cur[1:0]];
  // Count the wait, store enabled lanes at completion
  always @(posedge clock_i) begin
    if (strobe_i) begin
      q <= cur;
      act <= lag_i != 0;
      cnt <= lag_i - 2'h1;
    end else if (act) begin
      cnt <= cnt - 2'h1;
      act <= cnt != 0;
    end
    for (int b = 0; b < 4; b++)
      if (done_o && wr_i && cur[b + 2]) mem[cur[1:0]][8 * b +: 8] <= wdata_i[8 * b +: 8];
  end
endmodule

// *** test/tb_local_mem_bus_data_steering.sv ***
// Bench for the local bus master against the block RAM model.
// Model wait states are set per scenario through lag.
module tb_local_mem_bus_data_steering;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, sys_rst_i = 1, req_valid_i = 0, req_write_i = 0;
  logic [1:0] req_size_i = 0, lag = 0;
  logic [31:0] req_addr_i = 0, req_wdata_i = 0;
  wire req_ready_o, load_valid_o, addr_qualify_pulse_o, read_active_o, write_active_o, xfer_done_in_i;
  wire [3:0] byte_lanes_o;
  wire [31:0] load_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  int err_total = 0, num_checks = 0, cyc = 0;
  local_mem_bus_data_steering dut_u (.*);
  mem_model mem_u (.clock_i, .strobe_i(addr_qualify_pulse_o), .wr_i(write_active_o), .lag_i(lag),
    .lanes_i(byte_lanes_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .done_o(xfer_done_in_i), .rdata_o(mem_rdata_i));
  initial forever #20 clock_i = ~clock_i;
  // Cut a hang short
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      err_total++;
      finish_test();
    end
  end
  task check(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Present a request and hold it until accepted
  task put(input logic w, input logic [1:0] s, input logic [31:0] a, d);
    req_valid_i <= 1;
    req_write_i <= w;
    req_size_i <= s;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(negedge clock_i);
    for (int i = 0; i < 9 && !req_ready_o; i++) @(negedge clock_i);
    @(posedge clock_i);
  endtask
  // Load and compare the right-aligned result
  task ld(input logic [1:0] s, input logic [31:0] a, exp);
    put(0, s, a, 0);
    req_valid_i <= 0;
    @(negedge clock_i);
    for (int i = 0; i < 9 && load_valid_o !== 1; i++) @(negedge clock_i);
    check(load_data_o, exp);
    @(posedge clock_i);
  endtask
  task t_load_steer;
    put(1, 2, 32'h0, 32'h11223344);
    put(1, 2, 32'h4, 32'h55667788);
    for (int a = 0; a < 4; a++) ld(0, a, 32'h11223344 >> (8 * (3 - a)) & 32'hFF);
    ld(1, 2, 32'h3344);
    ld(1, 0, 32'h1122);
    ld(2, 4, 32'h55667788);
    $display("load steering done");
  endtask
  task t_store_steer;
    lag <= 2;
    put(1, 0, 32'h1, 32'hFFFFFFA5);
    put(1, 1, 32'h2, 32'h1234BEEF);
    put(1, 0, 32'h3, 32'h00000077);
    ld(2, 0, 32'h11A5BE77);
    lag <= 3;
    put(1, 2, 32'h8, 32'h0);
    req_valid_i <= 0;
    @(negedge clock_i);
    check(req_ready_o, 0);
    @(posedge clock_i);
    ld(2, 8, 32'h0);
    ld(0, 1, 32'hA5);
    $display("store steering done");
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 0;
    t_load_steer();
    t_store_steer();
    finish_test();
  end
endmodule
